// [include/pvcs_pkg.sv]
// Package: register map, field positions and reset values of the vendor registers
package pvcs_pkg;

    // =========================================================
    // Register offsets (management port addresses)
    localparam logic [4:0] ADDR_INTR_CTRL_STATUS = 5'h1b;
    localparam logic [4:0] ADDR_DEBUG_CTRL_ONE   = 5'h1c;
    localparam logic [4:0] ADDR_PHY_CTRL_STATUS  = 5'h1f;

    // =========================================================
    // Interrupt register fields
    localparam int EVT_LINK_UP      = 0;
    localparam int EVT_REMOTE_FAULT = 1;
    localparam int EVT_LINK_DOWN    = 2;
    localparam int EVT_PARTNER_ACK  = 3;
    localparam int EVT_COUNT        = 4;
    localparam int EVT_ENABLE_LSB   = 8;
    localparam int EVT_ENABLE_FULL  = 8;

    // =========================================================
    // Debug control fields
    localparam int DBG_CS_LOOPBACK  = 0;
    localparam int DBG_XOVER_OFF    = 6;
    localparam int DBG_STRAIGHT_SEL = 7;

    // =========================================================
    // PHY control/status fields
    localparam int PCS_LINK_CHK_FAIL = 1 - 1;
    localparam int PCS_SOFT_RESET    = 1;
    localparam int PCS_MASTER        = 2;
    localparam int PCS_DUPLEX        = 3;
    localparam int PCS_SPEED_10      = 4;
    localparam int PCS_SPEED_100     = 5;
    localparam int PCS_SPEED_1000    = 6;
    localparam int PCS_JABBER_EN     = 9;
    localparam int PCS_INT_POLARITY  = 14;

    // =========================================================
    // Reset values
    localparam logic [15:0] RST_INTR_CTRL_STATUS = 16'h0000;
    localparam logic [15:0] RST_DEBUG_CTRL_ONE   = 16'h0000;
    localparam logic [15:0] RST_PHY_CTRL_RW      = 16'h0200;

    // Writable masks; reserved RW bits store, RO bits do not
    localparam logic [15:0] WMASK_DEBUG_CTRL_ONE = 16'hffff;
    localparam logic [15:0] WMASK_PHY_CTRL       = 16'hf382;

endpackage : pvcs_pkg

// [rtl/pvcs_event_flags.sv]
// Sticky event flags, cleared by a read, with set winning over clear
`timescale 1ns/1ps
module pvcs_event_flags #(
    parameter int COUNT = 4
) (
    input  wire logic             sys_clk,
    input  wire logic             reset_n,
    input  wire logic [COUNT-1:0] event_in,
    input  wire logic             read_clear,
    output logic      [COUNT-1:0] flags
);
    typedef struct packed {
        logic [COUNT-1:0] sticky;
    } pvcs_flag_state_t;

    pvcs_flag_state_t state;
    pvcs_flag_state_t next_state;

    // Elaboration check: the flags share one byte of the register
    if (COUNT < 1 || COUNT > 8) begin : g_bad_count
        $error("pvcs_event_flags: COUNT must be 1..8");
    end

    // =========================================================
    // Per flag: a new event beats the read clear
    always_comb begin
        next_state = state;
        for (int i = 0; i < COUNT; i++) begin
            next_state.sticky[i] = event_in[i] | (state.sticky[i] & ~read_clear);
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign flags = state.sticky;
endmodule : pvcs_event_flags

// [rtl/pvcs_regs.sv]
// Vendor management registers: interrupt, debug control and PHY control/status
//
// Notes on behaviour
// - Four event flags, set on event, cleared by read
// - Crossover disable bit turns off auto crossover
// - Forced crossover: straight select picks MDI, else MDI-X
// - Straight select ignored while auto crossover runs
// - Loopback bit routes 10/100 loopback from control bit
// - Polarity bit sets interrupt pin active level
// - Jabber counter runs only while enable set
// - Resolved speed on three read-only bits
// - Duplex bit reads one for full duplex
// - Master/slave bit reads one for master
// - Software reset resets logic, keeps registers
// - Enable bit per flag in upper byte
`timescale 1ns/1ps
module pvcs_regs (
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    // Management register port
    input  wire logic [4:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic      [15:0] reg_rdata,
    // Events from the line logic, asynchronous levels or pulses
    input  wire logic        evt_link_up,
    input  wire logic        evt_remote_fault,
    input  wire logic        evt_link_down,
    input  wire logic        evt_partner_ack,
    // Resolved status from the line logic
    input  wire logic        stat_speed_1000,
    input  wire logic        stat_speed_100,
    input  wire logic        stat_speed_10,
    input  wire logic        stat_full_duplex,
    input  wire logic        stat_master,
    input  wire logic        stat_link_chk_fail,
    // Controls toward the line logic
    output logic             auto_xover_en,
    output logic             mdi_straight,
    output logic             coding_sublayer_loopback,
    output logic             jabber_count_en,
    output logic             soft_reset,
    output logic             int_pin
);
    localparam int NSTAT = 6;

    typedef struct packed {
        logic [7:0]  evt_enable;
        logic [15:0] debug_ctrl;
        logic [15:0] phy_ctrl;
        logic [3:0]  evt_prev;
        logic [15:0] rdata;
        logic        auto_xover_en;
        logic        mdi_straight;
        logic        cs_loopback;
        logic        jabber_en;
        logic        soft_reset;
        logic        int_pin;
    } pvcs_state_t;

    pvcs_state_t state;
    pvcs_state_t next_state;

    logic [3:0]       evt_sync;
    logic [NSTAT-1:0] stat_sync;
    logic [3:0]       evt_rise;
    logic [3:0]       flags;
    logic             intr_read;
    logic             any_pending;

    // =========================================================
    // Synchronisers: all line inputs cross from another domain
    pvcs_sync2 #(
        .WIDTH (4)
    ) u_sync_evt (
        .sys_clk  (sys_clk),
        .reset_n  (reset_n),
        .async_in ({evt_partner_ack, evt_link_down, evt_remote_fault, evt_link_up}),
        .sync_out (evt_sync)
    );

    pvcs_sync2 #(
        .WIDTH (NSTAT)
    ) u_sync_stat (
        .sys_clk  (sys_clk),
        .reset_n  (reset_n),
        .async_in ({stat_link_chk_fail, stat_master, stat_full_duplex,
                    stat_speed_10, stat_speed_100, stat_speed_1000}),
        .sync_out (stat_sync)
    );

    // Events count on the rising edge so a held level sets a flag once
    assign evt_rise  = evt_sync & ~state.evt_prev;
    assign intr_read = reg_read && (reg_addr == pvcs_pkg::ADDR_INTR_CTRL_STATUS);

    // =========================================================
    // Sticky flags of the interrupt register
    pvcs_event_flags #(
        .COUNT (pvcs_pkg::EVT_COUNT)
    ) u_flags (
        .sys_clk    (sys_clk),
        .reset_n    (reset_n),
        .event_in   (evt_rise),
        .read_clear (intr_read),
        .flags      (flags)
    );

    // Only the four documented flags have matching enables here
    assign any_pending = |(flags & state.evt_enable[3:0]);

    // =========================================================
    // Register writes, read mux and derived controls
    always_comb begin
        logic [15:0] status_word;
        logic        xover_off;
        status_word = '0;
        xover_off   = 1'b0;
        next_state  = state;
        next_state.evt_prev = evt_sync;

        if (reg_write) begin
            unique case (reg_addr)
                pvcs_pkg::ADDR_INTR_CTRL_STATUS: begin
                    next_state.evt_enable = reg_wdata[15:8];
                end
                pvcs_pkg::ADDR_DEBUG_CTRL_ONE: begin
                    next_state.debug_ctrl = reg_wdata & pvcs_pkg::WMASK_DEBUG_CTRL_ONE;
                end
                pvcs_pkg::ADDR_PHY_CTRL_STATUS: begin
                    next_state.phy_ctrl = reg_wdata & pvcs_pkg::WMASK_PHY_CTRL;
                end
                default: begin
                end
            endcase
        end

        // Status bits come live from the line, read-only
        status_word = state.phy_ctrl;
        status_word[pvcs_pkg::PCS_SPEED_1000]    = stat_sync[0];
        status_word[pvcs_pkg::PCS_SPEED_100]     = stat_sync[1];
        status_word[pvcs_pkg::PCS_SPEED_10]      = stat_sync[2];
        status_word[pvcs_pkg::PCS_DUPLEX]        = stat_sync[3];
        status_word[pvcs_pkg::PCS_MASTER]        = stat_sync[4];
        status_word[pvcs_pkg::PCS_LINK_CHK_FAIL] = stat_sync[5];

        // Read data stand in the cycle after the strobe only
        next_state.rdata = '0;
        if (reg_read) begin
            unique case (reg_addr)
                pvcs_pkg::ADDR_INTR_CTRL_STATUS: begin
                    next_state.rdata = {state.evt_enable, 4'h0, flags};
                end
                pvcs_pkg::ADDR_DEBUG_CTRL_ONE: begin
                    next_state.rdata = state.debug_ctrl;
                end
                pvcs_pkg::ADDR_PHY_CTRL_STATUS: begin
                    next_state.rdata = status_word;
                end
                default: begin
                    next_state.rdata = '0;
                end
            endcase
        end

        // Controls follow the register on the same edge, from its next value
        xover_off = next_state.debug_ctrl[pvcs_pkg::DBG_XOVER_OFF];
        next_state.auto_xover_en = ~xover_off;
        next_state.mdi_straight  = xover_off &
                                   next_state.debug_ctrl[pvcs_pkg::DBG_STRAIGHT_SEL];
        // Straight select masked while auto crossover runs
        if (!xover_off) begin
            next_state.mdi_straight = 1'b0;
        end
        next_state.cs_loopback = next_state.debug_ctrl[pvcs_pkg::DBG_CS_LOOPBACK];
        next_state.jabber_en   = next_state.phy_ctrl[pvcs_pkg::PCS_JABBER_EN];
        // Soft reset holds line logic; registers here are untouched by it
        next_state.soft_reset  = next_state.phy_ctrl[pvcs_pkg::PCS_SOFT_RESET];
        // Pin level follows polarity; active low idles high
        next_state.int_pin = any_pending ~^
                             next_state.phy_ctrl[pvcs_pkg::PCS_INT_POLARITY];
    end

    // =========================================================
    // State register; reset values from the package
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state               <= '0;
            state.evt_enable    <= pvcs_pkg::RST_INTR_CTRL_STATUS[15:8];
            state.debug_ctrl    <= pvcs_pkg::RST_DEBUG_CTRL_ONE;
            state.phy_ctrl      <= pvcs_pkg::RST_PHY_CTRL_RW;
            state.auto_xover_en <= 1'b1;
            state.jabber_en     <= 1'b1;
            state.int_pin       <= 1'b1;
        end else begin
            state <= next_state;
        end
    end

    assign reg_rdata                = state.rdata;
    assign auto_xover_en            = state.auto_xover_en;
    assign mdi_straight             = state.mdi_straight;
    assign coding_sublayer_loopback = state.cs_loopback;
    assign jabber_count_en          = state.jabber_en;
    assign soft_reset               = state.soft_reset;
    assign int_pin                  = state.int_pin;
endmodule : pvcs_regs

// [rtl/pvcs_sync2.sv]
// Two flip-flop synchroniser for a bus of levels from outside the clock domain
`timescale 1ns/1ps
module pvcs_sync2 #(
    parameter int WIDTH = 1
) (
    input  wire logic             sys_clk,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] stage_a;
        logic [WIDTH-1:0] stage_b;
    } pvcs_sync_state_t;

    pvcs_sync_state_t state;
    pvcs_sync_state_t next_state;

    // Elaboration check: a zero-width bus has nothing to carry
    if (WIDTH < 1) begin : g_bad_width
        $error("pvcs_sync2: WIDTH must be at least 1");
    end

    // =========================================================
    // Stage a feeds only stage b
    always_comb begin
        next_state         = state;
        next_state.stage_a = async_in;
        next_state.stage_b = state.stage_a;
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign sync_out = state.stage_b;
endmodule : pvcs_sync2

// [testbench/pvcs_regs_props.sv]
// Checker: port-level properties of the vendor register block
`timescale 1ns/1ps
module pvcs_regs_props (
    input wire logic        sys_clk,
    input wire logic        reset_n,
    input wire logic [4:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_write,
    input wire logic        reg_read,
    input wire logic [15:0] reg_rdata,
    input wire logic        stat_speed_1000,
    input wire logic        stat_speed_100,
    input wire logic        stat_speed_10,
    input wire logic        stat_full_duplex,
    input wire logic        stat_master,
    input wire logic        auto_xover_en,
    input wire logic        mdi_straight,
    input wire logic        coding_sublayer_loopback,
    input wire logic        jabber_count_en,
    input wire logic        soft_reset,
    input wire logic        int_pin
);
    // =========================================================
    // Helpers: decoded strobes and a shadow of the pin polarity
    wire logic       wr_dbg = reg_write && reg_addr == pvcs_pkg::ADDR_DEBUG_CTRL_ONE;
    wire logic       wr_phy = reg_write && reg_addr == pvcs_pkg::ADDR_PHY_CTRL_STATUS;
    wire logic       rd_int = reg_read && reg_addr == pvcs_pkg::ADDR_INTR_CTRL_STATUS;
    wire logic       rd_map = rd_int || reg_addr == pvcs_pkg::ADDR_DEBUG_CTRL_ONE
                              || reg_addr == pvcs_pkg::ADDR_PHY_CTRL_STATUS;
    wire logic [4:0] stat_vec = {stat_speed_1000, stat_speed_100, stat_speed_10,
                                 stat_full_duplex, stat_master};
    logic            pol_q;

    // Shadow polarity, so the pin check does not need internal state
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pol_q <= 1'b0;
        end else if (wr_phy) begin
            pol_q <= reg_wdata[pvcs_pkg::PCS_INT_POLARITY];
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    // =========================================================
    // Properties
    property p_xover;    wr_dbg |=> auto_xover_en == !$past(reg_wdata[6]); endproperty
    property p_straight; wr_dbg |=> mdi_straight == ($past(reg_wdata[6]) && $past(reg_wdata[7]));
    endproperty
    property p_loop;     wr_dbg |=> coding_sublayer_loopback == $past(reg_wdata[0]); endproperty
    property p_jabber;   wr_phy |=> jabber_count_en == $past(reg_wdata[9]); endproperty
    property p_srst;     wr_phy |=> soft_reset == $past(reg_wdata[1]); endproperty
    // Status must be steady long enough to cross the synchroniser
    property p_status;
        $stable(stat_vec)[*5] ##0 (reg_read && reg_addr == pvcs_pkg::ADDR_PHY_CTRL_STATUS)
            |=> reg_rdata[6:2] == $past(stat_vec);
    endproperty
    property p_flags_hi; rd_int |=> reg_rdata[7:4] == 4'h0; endproperty
    property p_int;      rd_int |=> int_pin == ((|(reg_rdata[11:8] & reg_rdata[3:0])) ~^ pol_q);
    endproperty
    property p_unmap;    reg_read && !rd_map |=> reg_rdata == 16'h0000; endproperty

    a_xover:    assert property (p_xover) else $error("crossover enable wrong");
    a_straight: assert property (p_straight) else $error("pair select wrong");
    a_loop:     assert property (p_loop) else $error("loopback wrong");
    a_jabber:   assert property (p_jabber) else $error("jabber enable wrong");
    a_srst:     assert property (p_srst) else $error("soft reset wrong");
    a_status:   assert property (p_status) else $error("status bits wrong");
    a_flags_hi: assert property (p_flags_hi) else $error("upper flags set");
    a_int:      assert property (p_int) else $error("interrupt pin wrong");
    a_unmap:    assert property (p_unmap) else $error("unmapped read nonzero");

    c_flag: cover property (rd_int ##1 reg_rdata[3:0] != 4'h0);
    c_xoff: cover property (wr_dbg ##1 !auto_xover_en);
    c_int:  cover property ($fell(int_pin));
endmodule : pvcs_regs_props

bind pvcs_regs pvcs_regs_props u_props (
    .sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .stat_speed_1000(stat_speed_1000), .stat_speed_100(stat_speed_100),
    .stat_speed_10(stat_speed_10), .stat_full_duplex(stat_full_duplex),
    .stat_master(stat_master), .auto_xover_en(auto_xover_en), .mdi_straight(mdi_straight),
    .coding_sublayer_loopback(coding_sublayer_loopback), .jabber_count_en(jabber_count_en),
    .soft_reset(soft_reset), .int_pin(int_pin));

// [testbench/pvcs_regs_tb.sv]
// Testbench: register table loop, reset, events and status of the vendor registers
`timescale 1ns/1ps
module pvcs_regs_tb;
    typedef struct packed {logic [4:0] a; logic [15:0] w; logic [15:0] r; logic [4:0] c;} pvcs_row_t;
    logic sys_clk, reset_n, reg_write, reg_read, fail;
    logic [4:0]  reg_addr, stat;
    logic [15:0] reg_wdata, reg_rdata, d, hits;
    logic [3:0]  evt;
    logic auto_xover_en, mdi_straight, coding_sublayer_loopback, jabber_count_en, soft_reset, int_pin;
    int n_mismatch = 0;
    int tests_run  = 0;
    wire logic [4:0] ctl = {auto_xover_en, mdi_straight, coding_sublayer_loopback,
                            jabber_count_en, soft_reset};
    // Rows: address, write data, read-back, controls {auto, straight, loop, jabber, sreset}
    pvcs_row_t rows [10] = '{
        '{5'h1c, 16'h0000, 16'h0000, 5'h12}, '{5'h1c, 16'h0080, 16'h0080, 5'h12},
        '{5'h1c, 16'h0040, 16'h0040, 5'h02}, '{5'h1c, 16'h00c0, 16'h00c0, 5'h0a},
        '{5'h1c, 16'hff01, 16'hff01, 5'h16}, '{5'h1f, 16'hffff, 16'hf382, 5'h17},
        '{5'h1f, 16'h0000, 16'h0000, 5'h14}, '{5'h1f, 16'h4200, 16'h4200, 5'h16},
        '{5'h05, 16'hffff, 16'h0000, 5'h16}, '{5'h1b, 16'hffff, 16'hff00, 5'h16}};

    pvcs_regs uut (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .evt_link_up(evt[0]), .evt_remote_fault(evt[1]), .evt_link_down(evt[2]),
        .evt_partner_ack(evt[3]), .stat_speed_1000(stat[4]), .stat_speed_100(stat[3]),
        .stat_speed_10(stat[2]), .stat_full_duplex(stat[1]), .stat_master(stat[0]),
        .stat_link_chk_fail(fail), .auto_xover_en(auto_xover_en), .mdi_straight(mdi_straight),
        .coding_sublayer_loopback(coding_sublayer_loopback), .jabber_count_en(jabber_count_en),
        .soft_reset(soft_reset), .int_pin(int_pin));

    // =========================================================
    // Clock and bus tasks; strobes last one cycle each
    initial sys_clk = 1'b0;
    always #12.5 sys_clk = ~sys_clk;

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic [4:0] a, input logic [15:0] w);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= w;
        reg_write <= 1'b1;
        @(posedge sys_clk);
        reg_write <= 1'b0;
    endtask : wr
    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [4:0] a, output logic [15:0] q);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge sys_clk);
        reg_read <= 1'b0;
        #1 q = reg_rdata;
    endtask : rd
    task automatic rdx(input logic [4:0] a, input logic [15:0] e);
        logic [15:0] q;
        rd(a, q);
        chk(q, e);
    endtask : rdx
    // Event pulse long enough for the synchroniser, then settle
    task automatic fire(input int i);
        @(posedge sys_clk);
        evt[i] <= 1'b1;
        repeat (2) @(posedge sys_clk);
        evt[i] <= 1'b0;
        repeat (6) @(posedge sys_clk);
        #1;
    endtask : fire
    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : tally_and_finish

    // =========================================================
    // Main sequence
    initial begin
        {reset_n, reg_write, reg_read, reg_addr, reg_wdata, evt, stat, fail} = '0;
        repeat (8) @(posedge sys_clk);
        reset_n <= 1'b1;
        for (int i = 0; i < 10; i++) begin
            wr(rows[i].a, rows[i].w);
            rdx(rows[i].a, rows[i].r);
            chk({11'h0, ctl}, {11'h0, rows[i].c});
        end
        // Second reset in mid-run restores defaults
        @(posedge sys_clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        #1 chk({10'h0, ctl, int_pin}, {10'h0, 5'h12, 1'b1});
        rdx(5'h1c, 16'h0000);
        rdx(5'h1f, 16'h0200);
        rdx(5'h1b, 16'h0000);
        // Each event with the active-low pin, then cleared by the read
        wr(5'h1b, 16'h0f00);
        for (int i = 0; i < 4; i++) begin
            fire(i);
            chk({15'h0, int_pin}, 16'h0000);
            rdx(5'h1b, 16'h0f00 | (16'h0001 << i));
            repeat (2) @(posedge sys_clk);
            #1 chk({15'h0, int_pin}, 16'h0001);
            rdx(5'h1b, 16'h0f00);
        end
        // Masked flag still latches but leaves the pin idle
        wr(5'h1b, 16'h0e00);
        fire(0);
        chk({15'h0, int_pin}, 16'h0001);
        rdx(5'h1b, 16'h0e01);
        // Active-high polarity
        wr(5'h1f, 16'h4200);
        wr(5'h1b, 16'h0100);
        fire(0);
        chk({15'h0, int_pin}, 16'h0001);
        rdx(5'h1b, 16'h0101);
        repeat (2) @(posedge sys_clk);
        #1 chk({15'h0, int_pin}, 16'h0000);
        // Event near a clearing read is reported exactly once, at two phases
        for (int k = 0; k < 2; k++) begin
            repeat (k) @(posedge sys_clk);
            evt[2] <= 1'b1;
            hits = 16'h0000;
            repeat (4) begin
                rd(5'h1b, d);
                hits = hits + {15'h0, d[2]};
            end
            chk(hits, 16'h0001);
            evt[2] <= 1'b0;
            repeat (4) @(posedge sys_clk);
        end
        // Live status bits beside the stored control bits
        stat <= 5'h15;
        fail <= 1'b1;
        repeat (6) @(posedge sys_clk);
        rdx(5'h1f, 16'h4255);
        stat <= 5'h0a;
        fail <= 1'b0;
        repeat (6) @(posedge sys_clk);
        rdx(5'h1f, 16'h4228);
        tally_and_finish();
    end

    // Watchdog, well beyond the few hundred cycles the tests need
    initial begin
        repeat (5000) @(posedge sys_clk);
        n_mismatch++;
        tally_and_finish();
    end
endmodule : pvcs_regs_tb
